// file: hdl/pfbi_host.sv
// Purpose: host controller driving a byte-wide parallel flash bus
// Assumes: 100 MHz clock; flash pins are asynchronous
// Notes: pulses flash reset after controller reset
//
// Functional notes
// - Read: select and gate low, strobe high
// - Write: strobe and select low, gate high
// - Wait select access time before reading data
// - Flag operation interrupted by flash reset
// - Wait release time after reset before reading
`timescale 1ns/100ps
`default_nettype none
`include "pfbi_map.svh"

module pfbi_host
  import pfbi_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic arst_n_in,
  // User request
  input wire logic req_in,
  input wire logic req_write_in,
  input wire logic [20:0] req_addr_in,
  input wire logic [7:0] req_wdata_in,
  input wire logic flash_reset_req_in,
  // User answer
  output logic ready_out,
  output logic ack_out,
  output logic [7:0] rdata_out,
  output logic busy_out,
  output logic aborted_out,
  // Flash control pins
  output logic sel_n_out,
  output logic gate_n_out,
  output logic wstrobe_n_out,
  output logic init_n_out,
  output logic [20:0] byte_address_lines_out,
  // Flash data pins and busy flag
  output logic [7:0] data_pins_out,
  output logic data_pins_oe_n_out,
  input wire logic [7:0] data_pins_in,
  input wire logic done_flag_n_in
);

  localparam int SEL_WAIT = `PFBI_SEL_ACCESS_CYC + `PFBI_SYNC_CYC;
  localparam int PULSE_CYC = `PFBI_INIT_PULSE_CYC;
  localparam int REL_CYC = `PFBI_INIT_RELEASE_CYC;
  localparam int READY_CYC = `PFBI_READY_CYC;
  localparam int WR_CYC = `PFBI_WR_PULSE_CYC;

  function automatic logic reached(pfbi_cnt_t cnt, int lim);
    return 32'(cnt) >= lim;
  endfunction

  function automatic pfbi_cnt_t sat_inc(pfbi_cnt_t cnt);
    return (cnt == 16'hFFFF) ? cnt : cnt + 16'h0001;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser

  logic [8:0] sync_pins;
  pfbi_data_t data_sync;
  logic flash_idle_sync;

  pfbi_sync u_sync (
    .mclk_in(mclk_in),
    .arst_n_in(arst_n_in),
    .pins_in({done_flag_n_in, data_pins_in}),
    .pins_out(sync_pins)
  );

  assign data_sync = sync_pins[7:0];
  assign flash_idle_sync = sync_pins[8];

  ////////////////////////////////////////////////////////////////////////////
  // Controller state

  pfbi_state_t state_reg, state_next;
  pfbi_cnt_t cnt_reg, cnt_next;
  logic ready_reg, ready_next;
  logic ack_reg, ack_next;
  pfbi_data_t rdata_reg, rdata_next;
  logic busy_reg, busy_next;
  logic aborted_reg, aborted_next;
  logic sel_n_reg, sel_n_next;
  logic gate_n_reg, gate_n_next;
  logic wstrobe_n_reg, wstrobe_n_next;
  logic init_n_reg, init_n_next;
  pfbi_addr_t addr_reg, addr_next;
  pfbi_data_t wdata_reg, wdata_next;
  logic oe_n_reg, oe_n_next;

  always_comb begin
    state_next = state_reg;
    cnt_next = sat_inc(cnt_reg);
    ready_next = 1'b0;
    ack_next = 1'b0;
    rdata_next = rdata_reg;
    busy_next = !flash_idle_sync;
    aborted_next = aborted_reg;
    sel_n_next = sel_n_reg;
    gate_n_next = gate_n_reg;
    wstrobe_n_next = wstrobe_n_reg;
    init_n_next = init_n_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    oe_n_next = oe_n_reg;
    unique case (state_reg)
      PFBI_ST_RST_LOW: begin
        if (reached(cnt_reg, PULSE_CYC - 1)) begin
          init_n_next = 1'b1;
          cnt_next = 16'h0000;
          state_next = PFBI_ST_RST_REC;
        end
      end
      PFBI_ST_RST_REC: begin
        // Release time, then busy flag high or the ready bound
        if (reached(cnt_reg, REL_CYC) &&
            (flash_idle_sync || reached(cnt_reg, READY_CYC))) begin
          ready_next = 1'b1;
          state_next = PFBI_ST_IDLE;
        end
      end
      PFBI_ST_IDLE: begin
        ready_next = 1'b1;
        if (flash_reset_req_in) begin
          ready_next = 1'b0;
          aborted_next = aborted_reg | !flash_idle_sync;
          init_n_next = 1'b0;
          cnt_next = 16'h0000;
          state_next = PFBI_ST_RST_LOW;
        end else if (req_in) begin
          ready_next = 1'b0;
          addr_next = req_addr_in;
          wdata_next = req_wdata_in;
          sel_n_next = 1'b0;
          cnt_next = 16'h0000;
          if (req_write_in) begin
            aborted_next = 1'b0;
            oe_n_next = 1'b0;
            state_next = PFBI_ST_WR_SETUP;
          end else begin
            gate_n_next = 1'b0;
            state_next = PFBI_ST_RD_WAIT;
          end
        end
      end
      PFBI_ST_RD_WAIT: begin
        if (reached(cnt_reg, SEL_WAIT)) begin
          rdata_next = data_sync;
          ack_next = 1'b1;
          sel_n_next = 1'b1;
          gate_n_next = 1'b1;
          ready_next = 1'b1;
          state_next = PFBI_ST_IDLE;
        end
      end
      PFBI_ST_WR_SETUP: begin
        wstrobe_n_next = 1'b0;
        cnt_next = 16'h0000;
        state_next = PFBI_ST_WR_PULSE;
      end
      PFBI_ST_WR_PULSE: begin
        if (reached(cnt_reg, WR_CYC - 1)) begin
          wstrobe_n_next = 1'b1;
          sel_n_next = 1'b1;
          state_next = PFBI_ST_WR_HOLD;
        end
      end
      PFBI_ST_WR_HOLD: begin
        oe_n_next = 1'b1;
        ack_next = 1'b1;
        ready_next = 1'b1;
        state_next = PFBI_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg <= PFBI_ST_RST_LOW;
      cnt_reg <= 16'h0000;
      ready_reg <= 1'b0;
      ack_reg <= 1'b0;
      rdata_reg <= 8'h00;
      busy_reg <= 1'b0;
      aborted_reg <= 1'b0;
      sel_n_reg <= 1'b1;
      gate_n_reg <= 1'b1;
      wstrobe_n_reg <= 1'b1;
      init_n_reg <= 1'b0;
      addr_reg <= 21'h000000;
      wdata_reg <= 8'h00;
      oe_n_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      ready_reg <= ready_next;
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
      busy_reg <= busy_next;
      aborted_reg <= aborted_next;
      sel_n_reg <= sel_n_next;
      gate_n_reg <= gate_n_next;
      wstrobe_n_reg <= wstrobe_n_next;
      init_n_reg <= init_n_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      oe_n_reg <= oe_n_next;
    end
  end

  assign ready_out = ready_reg;
  assign ack_out = ack_reg;
  assign rdata_out = rdata_reg;
  assign busy_out = busy_reg;
  assign aborted_out = aborted_reg;
  assign sel_n_out = sel_n_reg;
  assign gate_n_out = gate_n_reg;
  assign wstrobe_n_out = wstrobe_n_reg;
  assign init_n_out = init_n_reg;
  assign byte_address_lines_out = addr_reg;
  assign data_pins_out = wdata_reg;
  assign data_pins_oe_n_out = oe_n_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  pfbi_cnt_t sel_low_cnt_reg, sel_low_cnt_next;
  pfbi_cnt_t init_low_cnt_reg, init_low_cnt_next;
  pfbi_cnt_t init_high_cnt_reg, init_high_cnt_next;

  always_comb begin
    sel_low_cnt_next = sel_n_reg ? 16'h0000 : sat_inc(sel_low_cnt_reg);
    init_low_cnt_next = init_n_reg ? 16'h0000 : sat_inc(init_low_cnt_reg);
    init_high_cnt_next = init_n_reg ? sat_inc(init_high_cnt_reg) : 16'h0000;
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sel_low_cnt_reg <= 16'h0000;
      init_low_cnt_reg <= 16'h0000;
      init_high_cnt_reg <= 16'h0000;
    end else begin
      sel_low_cnt_reg <= sel_low_cnt_next;
      init_low_cnt_reg <= init_low_cnt_next;
      init_high_cnt_reg <= init_high_cnt_next;
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);

  sequence s_wr_pulse;
    (!wstrobe_n_reg && !sel_n_reg && gate_n_reg && !oe_n_reg)[*4];
  endsequence

  sequence s_wr_release;
    wstrobe_n_reg && sel_n_reg && !oe_n_reg ##1 oe_n_reg && ack_reg;
  endsequence

  a_read_levels: assert property (
    !gate_n_reg |-> (wstrobe_n_reg && !sel_n_reg))
    else $error("gate low without select low and strobe high");

  a_write_levels: assert property (
    !wstrobe_n_reg |-> (gate_n_reg && !sel_n_reg))
    else $error("strobe low without select low and gate high");

  a_write_pulse: assert property (
    $fell(wstrobe_n_reg) |-> s_wr_pulse ##1 s_wr_release)
    else $error("write pulse shape wrong");

  a_select_access: assert property (
    (state_reg == PFBI_ST_RD_WAIT && state_next == PFBI_ST_IDLE)
      |-> (32'(sel_low_cnt_reg) >= SEL_WAIT) ##1 (ack_reg && sel_n_reg))
    else $error("read data taken before select access time");

  a_reset_width: assert property (
    $rose(init_n_reg) |-> 32'(init_low_cnt_reg) >= PULSE_CYC)
    else $error("flash reset pulse too short");

  a_release_wait: assert property (
    $fell(sel_n_reg) |-> 32'(init_high_cnt_reg) > REL_CYC)
    else $error("access before reset release time");

  a_bus_free: assert property (
    $fell(gate_n_reg) |-> ($past(oe_n_reg) && oe_n_reg))
    else $error("gate asserted while host drives data");

  a_abort_flag: assert property (
    (state_reg == PFBI_ST_IDLE && flash_reset_req_in && !flash_idle_sync)
      |=> aborted_reg && !init_n_reg)
    else $error("interrupted operation not flagged");

endmodule

`default_nettype wire

// file: hdl/pfbi_map.svh
// Purpose: constants of the parallel flash host controller
// Assumes: 100 MHz controller clock
// Notes: times in ns, counts in cycles derived from them
`ifndef PFBI_MAP_SVH
`define PFBI_MAP_SVH

`define PFBI_CLK_NS 10
`define PFBI_ADDR_W 21
`define PFBI_DATA_W 8
`define PFBI_SYNC_CYC 2

// Flash timing figures, plain defaults
`define PFBI_SEL_ACCESS_NS 90
`define PFBI_INIT_PULSE_MIN_NS 500
`define PFBI_INIT_RELEASE_READ_NS 50
`define PFBI_READY_MAX_NS 20000
`define PFBI_WR_PULSE_NS 40

// Least times round up, the ready bound rounds down
`define PFBI_SEL_ACCESS_CYC ((`PFBI_SEL_ACCESS_NS + `PFBI_CLK_NS - 1) / `PFBI_CLK_NS)
`define PFBI_INIT_PULSE_CYC ((`PFBI_INIT_PULSE_MIN_NS + `PFBI_CLK_NS - 1) / `PFBI_CLK_NS)
`define PFBI_INIT_RELEASE_CYC ((`PFBI_INIT_RELEASE_READ_NS + `PFBI_CLK_NS - 1) / `PFBI_CLK_NS)
`define PFBI_READY_CYC (`PFBI_READY_MAX_NS / `PFBI_CLK_NS)
`define PFBI_WR_PULSE_CYC ((`PFBI_WR_PULSE_NS + `PFBI_CLK_NS - 1) / `PFBI_CLK_NS)

`endif

// file: hdl/pfbi_pkg.sv
// Purpose: types of the parallel flash host controller
// Assumes: pfbi_map.svh for widths
// Notes: one-hot controller states
`include "pfbi_map.svh"

package pfbi_pkg;

  typedef enum logic [6:0] {
    PFBI_ST_RST_LOW  = 7'b0000001,
    PFBI_ST_RST_REC  = 7'b0000010,
    PFBI_ST_IDLE     = 7'b0000100,
    PFBI_ST_RD_WAIT  = 7'b0001000,
    PFBI_ST_WR_SETUP = 7'b0010000,
    PFBI_ST_WR_PULSE = 7'b0100000,
    PFBI_ST_WR_HOLD  = 7'b1000000
  } pfbi_state_t;

  typedef logic [15:0] pfbi_cnt_t;
  typedef logic [`PFBI_ADDR_W-1:0] pfbi_addr_t;
  typedef logic [`PFBI_DATA_W-1:0] pfbi_data_t;

endpackage

// file: hdl/pfbi_sync.sv
// Purpose: two-flop synchroniser for the flash pin inputs
// Assumes: inputs asynchronous to mclk_in
// Notes: first stage is read only by the second
`timescale 1ns/100ps
`default_nettype none

module pfbi_sync
  import pfbi_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic arst_n_in,
  // Raw pins
  input wire logic [8:0] pins_in,
  // Synchronised
  output logic [8:0] pins_out
);

  logic [8:0] stage1_reg;
  logic [8:0] stage2_reg;

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      stage1_reg <= 9'h1FF;
      stage2_reg <= 9'h1FF;
    end else begin
      stage1_reg <= pins_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign pins_out = stage2_reg;

endmodule

`default_nettype wire

// file: tb/pfbi_flash_model.sv
// Purpose: behavioural byte-wide flash for the host controller bench
// Assumes: clk_in paces busy and ready timers, the access check and the float pattern
// Notes: command codes and id code are arbitrary values
`timescale 1ns/100ps
`default_nettype none

module pfbi_flash_model #(
  parameter int ACC_NS = 90,
  parameter int BUSY_CYC = 300,
  parameter int RDY_CYC = 100,
  parameter logic [7:0] ID_CODE = 8'hC3,
  parameter logic [7:0] STAT = 8'h4C,
  parameter logic [7:0] CMD_ID = 8'h90,
  parameter logic [7:0] CMD_ARRAY = 8'hF0,
  parameter logic [7:0] CMD_ERASE = 8'hB5
) (
  // Pacing clock
  input wire logic clk_in,
  // Control pins
  input wire logic sel_n_in,
  input wire logic gate_n_in,
  input wire logic wstrobe_n_in,
  input wire logic init_n_in,
  // Address and data
  input wire logic [20:0] addr_in,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic done_flag_n_out
);
  logic [7:0] mem [256];
  logic [7:0] pend_a, pend_d, noise;
  logic id_mode, armed, busy, acc_ok, erase_all;
  int cnt, rcnt;
  realtime sel_t;

  initial begin
    for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'h5A;
    {id_mode, armed, busy, acc_ok, erase_all} = 5'h00;
    {cnt, rcnt} = '0;
    sel_t = 0.0;
    noise = 8'h00;
  end
  always @(negedge sel_n_in) sel_t = $realtime;
  always @(negedge wstrobe_n_in) armed = !sel_n_in && gate_n_in && init_n_in;
  always @(posedge wstrobe_n_in) begin
    if (armed && init_n_in) begin
      if (data_in == CMD_ID) id_mode = 1'b1;
      else if (data_in == CMD_ARRAY) id_mode = 1'b0;
      else if (!busy) begin
        erase_all = (data_in == CMD_ERASE);
        pend_a = addr_in[7:0];
        pend_d = data_in;
        cnt = BUSY_CYC;
        busy = 1'b1;
      end
    end
    armed = 1'b0;
  end
  always @(negedge init_n_in) begin
    rcnt = busy ? RDY_CYC : 0;
    {id_mode, armed, busy} = 3'h0;
  end
  always @(posedge clk_in) begin
    noise <= noise + 8'h3B;
    acc_ok <= !sel_n_in && ($realtime - sel_t >= ACC_NS);
    if (rcnt > 0) rcnt <= rcnt - 1;
    if (busy && init_n_in) begin
      // Erase clears the whole array; all sectors alias in this small model
      if (cnt == 1 && erase_all) for (int i = 0; i < 256; i++) mem[i] <= 8'hFF;
      if (cnt == 1 && !erase_all) mem[pend_a] <= pend_d;
      if (cnt == 1) busy <= 1'b0;
      cnt <= cnt - 1;
    end
  end
  // Floats as a changing pattern when not driven
  always_comb begin
    data_out = noise;
    if (!sel_n_in && !gate_n_in && wstrobe_n_in && init_n_in && acc_ok) begin
      data_out = busy ? STAT : id_mode ? ID_CODE : mem[addr_in[7:0]];
    end
  end
  assign done_flag_n_out = !(busy || rcnt != 0);
endmodule
`default_nettype wire

// file: tb/pfbi_host_bench.sv
// Purpose: self-checking bench of the flash host controller
// Assumes: flash model on the pin side
// Notes: random addresses and data from a fixed-seed shift register
`timescale 1ns/100ps
`default_nettype none

module pfbi_host_bench;
  import pfbi_pkg::*;
  localparam logic [7:0] ID = 8'hC3, ST = 8'h4C, CID = 8'h90, CARR = 8'hF0, ERS = 8'hB5;
  logic mclk_in = 0, arst_n_in = 0, req = 0, req_wr = 0, frst = 0;
  logic [20:0] req_addr = '0, addr, fa;
  logic [7:0] req_wdata = '0, rdata, fd, hd, pins, flash_q, shadow [256];
  logic ready, ack, busy, aborted, sel_n, gate_n, wstr_n, init_n, oe_n, flag_n;
  logic [15:0] lfsr = 16'h0BD9;
  int n_mismatch = 0, cmp_count = 0, cycles = 0;

  assign pins = oe_n ? flash_q : hd;
  pfbi_host dut (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .req_in(req),
    .req_write_in(req_wr), .req_addr_in(req_addr), .req_wdata_in(req_wdata),
    .flash_reset_req_in(frst), .ready_out(ready), .ack_out(ack), .rdata_out(rdata),
    .busy_out(busy), .aborted_out(aborted), .sel_n_out(sel_n), .gate_n_out(gate_n),
    .wstrobe_n_out(wstr_n), .init_n_out(init_n), .byte_address_lines_out(addr),
    .data_pins_out(hd), .data_pins_oe_n_out(oe_n), .data_pins_in(pins),
    .done_flag_n_in(flag_n));
  pfbi_flash_model flash (.clk_in(mclk_in), .sel_n_in(sel_n), .gate_n_in(gate_n),
    .wstrobe_n_in(wstr_n), .init_n_in(init_n), .addr_in(addr), .data_in(pins),
    .data_out(flash_q), .done_flag_n_out(flag_n));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] expect_rd(logic [20:0] a);
    return shadow[a[7:0]];
  endfunction
  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    fa = {lfsr[12:0], lfsr[15:8]};
    fd = {1'b0, lfsr[6:0]};
  endtask
  task automatic op(logic wr, logic rs, logic [20:0] a, logic [7:0] d);
    int i;
    i = 0;
    @(negedge mclk_in);
    while (ready !== 1'b1 && i < 3000) begin
      @(negedge mclk_in);
      i++;
    end
    {req, frst, req_wr, req_addr, req_wdata} = {!rs, rs, wr, a, d};
    @(negedge mclk_in);
    {req, frst} = 2'b00;
    i = 0;
    while (!rs && ack !== 1'b1 && i < 40) begin
      @(negedge mclk_in);
      i++;
    end
    if (!rs) chk("ack", {7'h0, ack}, 8'h01);
    if (!rs) chk("ready", {7'h0, ready}, 8'h01);
  endtask
  task automatic rd(logic [20:0] a, logic [7:0] exp);
    op(1'b0, 1'b0, a, 8'h00);
    chk("rdata", rdata, exp);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial forever #5 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    for (int i = 0; i < 256; i++) shadow[i] = i[7:0] ^ 8'h5A;
    repeat (2) @(posedge mclk_in);
    @(negedge mclk_in) arst_n_in = 1'b1;
    rd(21'h000000, expect_rd(21'h000000));
    rd(21'h1FFFFF, expect_rd(21'h1FFFFF));
    for (int k = 0; k < 6; k++) begin
      rnd();
      rd(fa, expect_rd(fa));
    end
    rnd();
    op(1'b1, 1'b0, fa, fd);
    rd(fa, ST);
    chk("busy", {7'h0, busy}, 8'h01);
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(negedge mclk_in);
    chk("busy", {7'h0, busy}, 8'h00);
    shadow[fa[7:0]] = fd;
    rd(fa, fd);
    op(1'b1, 1'b0, 21'h000555, CID);
    rd(fa, ID);
    op(1'b1, 1'b0, 21'h000555, CARR);
    rd(fa, expect_rd(fa));
    rnd();
    op(1'b1, 1'b0, fa, fd);
    repeat (20) @(negedge mclk_in);
    op(1'b0, 1'b1, 21'h000000, 8'h00);
    op(1'b0, 1'b0, fa, 8'h00);
    chk("aborted", {7'h0, aborted}, 8'h01);
    chk("rdata", rdata, expect_rd(fa));
    op(1'b1, 1'b0, 21'h000000, CARR);
    chk("aborted", {7'h0, aborted}, 8'h00);
    op(1'b1, 1'b0, 21'h000555, CID);
    op(1'b0, 1'b1, 21'h000000, 8'h00);
    rd(fa, expect_rd(fa));
    op(1'b1, 1'b0, 21'h1F0000, ERS);
    rd(fa, ST);
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(negedge mclk_in);
    chk("busy", {7'h0, busy}, 8'h00);
    for (int i = 0; i < 256; i++) shadow[i] = 8'hFF;
    rd(fa, expect_rd(fa));
    wrap_up();
  end
endmodule
`default_nettype wire
